// file: verification/flash_dev_model.sv
/*
   Behavioural dual-bank flash: command decode, timers, status bits.
   Assumes the controller's registered pins, sampled on its clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter int PROG_CYC = 60,
   parameter int ERASE_CYC = 600,
   parameter logic [19:0] BOOT_TOP = 20'h01fff
) (
   input wire logic clk,
   input wire flash_host_pkg::flash_out_t fo,
   output flash_host_pkg::flash_in_t fi
);
   import flash_host_pkg::*;
   logic [15:0] mem [int]; // Programmed words only
   int step = 0, busy = 0, low_cyc = 0;
   logic prog = 0, chip = 0, susp = 0, erased = 0, wr_q = 0, oe_q = 1, t6 = 0, t2 = 0, drv;
   logic [19:0] oa = 20'h0, wa_q = 20'h0; // Running operation, last write cycle
   logic [15:0] rd = 16'h0, pd = 16'h0, wd_q = 16'h0;
   function automatic logic [15:0] arr(input logic [19:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : (erased ? 16'hffff : a[15:0] ^ 16'h3c3c);
   endfunction : arr
   assign drv = !fo.oe_n && !fo.flash_bank_select_n;
   assign fi.op_progress_flag_n = !(busy > 0 && !susp);
   // Released pins show the inverse, never a kind stale value
   assign fi.dq_in = drv ? (fo.bus_width_select ? rd : {~rd[15:8], rd[7:0]}) : ~rd;
   // One write cycle of the command set
   task automatic cmd(input logic [19:0] a, input logic [15:0] d);
      if (busy > 0 && !susp) begin
         if (d[7:0] == 8'hb0 && !prog && !chip) susp <= 1'b1;
      end else if (susp && step == 0 && d[7:0] == 8'h30) begin
         susp <= 1'b0;
      end else begin
         case (step)
            0: step <= (a == 20'h555 && d[7:0] == 8'haa) ? 1 : 0;
            1, 4: step <= (a == 20'h2aa && d[7:0] == 8'h55) ? step + 1 : 0;
            2: begin
               prog <= d[7:0] == 8'ha0;
               step <= (a == 20'h555 && (d[7:0] == 8'ha0 || d[7:0] == 8'h80)) ? 3 : 0;
            end
            3: if (prog) begin
               step <= 0;
               if (!(susp && a[19:11] == oa[19:11]) && (fo.wp_n || a > BOOT_TOP)) begin
                  mem[int'(a)] = d;
                  pd <= d;
                  if (!susp) begin
                     busy <= PROG_CYC;
                     oa <= a;
                  end
               end
            end else step <= (a == 20'h555 && d[7:0] == 8'haa) ? 4 : 0;
            default: begin
               step <= 0;
               if (a == 20'h555 && d[7:0] == 8'h10 && fo.wp_n) begin
                  chip <= 1'b1;
                  busy <= ERASE_CYC;
                  oa <= a;
                  mem.delete();
                  erased <= 1'b1;
               end else if ((d[7:0] == 8'h30 || d[7:0] == 8'h50) && (fo.wp_n || a > BOOT_TOP)) begin
                  chip <= 1'b0;
                  busy <= ERASE_CYC;
                  oa <= a;
               end
            end
         endcase
      end
   endtask : cmd
   // Strobe edges, timers and status reads
   always @(posedge clk) begin
      // A write cycle ends at the earlier rise of strobe or select
      wr_q <= !fo.we_n && !fo.flash_bank_select_n && fo.oe_n;
      wa_q <= fo.addr;
      wd_q <= fo.dq_out;
      oe_q <= fo.oe_n;
      low_cyc <= (!fo.we_n && !fo.flash_bank_select_n) ? low_cyc + 1 : 0;
      if (busy > 0 && !susp) busy <= busy - 1;
      if (!fo.reset_n) begin
         busy <= 0;
         susp <= 1'b0;
         step <= 0;
      end else if (wr_q && (fo.we_n || fo.flash_bank_select_n) && low_cyc >= 1) begin
         cmd(wa_q, wd_q);
      end
      if (drv && oe_q) begin
         if (busy > 0 && !susp && fo.addr[19] == oa[19]) begin
            t6 <= !t6;
            t2 <= prog ? t2 : !t2;
            rd <= {8'h0, prog ? ~pd[7] : 1'b0, !t6, 3'h0, prog ? t2 : !t2, 2'h0};
         end else if (susp && fo.addr[19:11] == oa[19:11]) begin
            t2 <= !t2;
            rd <= {8'h0, 2'b11, 3'h0, !t2, 2'h0};
         end else rd <= arr(fo.addr);
      end
   end
endmodule : flash_dev_model
`default_nettype wire

// file: verification/flash_host_ctrl_asserts.sv
/*
   Checker of the flash host controller's pins and APB answer.
   Assumes it is bound into flash_host_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_asserts #(
   parameter int RESET_PULSE_NS = 500
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire flash_host_pkg::flash_out_t flash_out,
   input wire flash_host_pkg::flash_in_t flash_in
);
   import flash_host_pkg::*;
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   localparam int RST_MIN = RESET_PULSE_NS / 5; // Floor, so a rounded-up pulse still passes
   logic [15:0] rst_low; // Cycles the flash reset pin has been low
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Count reset pin low time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_low <= 16'h0;
      end else begin
         rst_low <= flash_out.reset_n ? 16'h0 : rst_low + 16'h1;
      end
   end
   // A whole write strobe: eight low cycles, then high
   sequence s_strobe;
      (!flash_out.we_n) [*8] ##1 flash_out.we_n;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_we_width: assert property ($fell(flash_out.we_n) |-> s_strobe)
      else $error("write strobe width wrong");
   a_no_we_oe: assert property (!(!flash_out.we_n && !flash_out.oe_n))
      else $error("write and output strobes low together");
   a_we_select: assert property (!flash_out.we_n |-> !flash_out.flash_bank_select_n)
      else $error("write strobe without select");
   a_oe_select: assert property (!flash_out.oe_n |-> !flash_out.flash_bank_select_n)
      else $error("read strobe without select");
   a_addr_hold: assert property (!flash_out.we_n |-> $stable(flash_out.addr) && $stable(flash_out.dq_out))
      else $error("address or data moved in strobe");
   a_byte_float: assert property (!flash_out.bus_width_select |-> &flash_out.dq_oe_n[14:8])
      else $error("upper pins driven in byte mode");
   a_wide_drive: assert property (!flash_out.we_n && flash_out.bus_width_select |-> flash_out.dq_oe_n == 16'h0)
      else $error("data pins not all driven in write");
   a_read_release: assert property (!flash_out.oe_n |-> &flash_out.dq_oe_n[14:0])
      else $error("data pins driven during read");
   a_wp_hold: assert property (!flash_in.op_progress_flag_n |-> $stable(flash_out.wp_n))
      else $error("protect level moved while busy");
   a_reset_width: assert property ($rose(flash_out.reset_n) |-> rst_low >= RST_MIN)
      else $error("reset pulse too short");
   a_pready_now: assert property (psel && penable |-> pready)
      else $error("access not answered");
endmodule : flash_host_ctrl_asserts

bind flash_host_ctrl flash_host_ctrl_asserts #(.RESET_PULSE_NS(RESET_PULSE_NS)) u_asserts (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_out(flash_out), .flash_in(flash_in));
`default_nettype wire

// file: verification/test_flash_host_ctrl.sv
/*
   Self-checking bench of the flash host controller over APB.
   Assumes the flash model of this folder on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.svh"
module test_flash_host_ctrl;
   import flash_host_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [19:0] a;
   logic [15:0] d;
   flash_out_t fo;
   flash_in_t fi;
   int errors = 0, compares = 0, cyc = 0;
   always #2.5 pclk = ~pclk;
   flash_host_ctrl #(.RESET_PULSE_NS(10), .RESET_RECOVERY_NS(10)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_out(fo), .flash_in(fi));
   flash_dev_model u_flash (.clk(pclk), .fo(fo), .fi(fi));
   // Hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors = errors + 1;
         test_done();
      end
   end
   function automatic logic [15:0] arr_exp(input logic [19:0] ad);
      return ad[15:0] ^ 16'h3c3c;
   endfunction : arr_exp
   // One APB transfer; r and e hold the answer
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic order(input logic [3:0] op);
      apb(1'b1, `REG_CTRL, {28'h0, op});
   endtask : order
   // Polls status until the bit or the bound; the bound counts as a mismatch
   task automatic wait_bit(input int b);
      for (int n = 0; n < 3000; n++) begin
         apb(1'b0, `REG_STATUS, 32'h0);
         if (r[b] === 1'b1) return;
      end
      errors++;
      $display("Error status bit %0d expected 1 seen %b", b, r[b]);
   endtask : wait_bit
   task automatic rd_word(input logic [19:0] ad);
      apb(1'b1, `REG_ADDR, {12'h0, ad});
      order(OP_READ);
      wait_bit(2);
      apb(1'b0, `REG_RDATA, 32'h0);
   endtask : rd_word
   task automatic chk_reg(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         errors++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask : chk_reg
   task automatic chk_pin(input string n, input logic x, input logic g);
      compares++;
      if (g !== x) begin
         errors++;
         $display("Error %s expected %b seen %b", n, x, g);
      end
   endtask : chk_pin
   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      r = $urandom(57363);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk_pin("wp_n", 1'b1, fo.wp_n);
      chk_pin("select", 1'b1, fo.flash_bank_select_n);
      apb(1'b0, `REG_CFG, 32'h0);
      chk_reg("cfg", 32'h3, r);
      apb(1'b0, 12'h020, 32'h0);
      chk_pin("pslverr", 1'b1, e);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         a = (i == 0) ? 20'h0 : (i == 1) ? 20'hfffff : 20'($urandom);
         rd_word(a);
         chk_reg("read", {16'h0, arr_exp(a)}, r);
      end
      $display("test read done");
      a = 20'h04000 | 20'($urandom & 32'h3fff);
      d = 16'($urandom);
      apb(1'b1, `REG_WDATA, {16'h0, d});
      apb(1'b1, `REG_ADDR, {12'h0, a});
      order(OP_PROGRAM);
      wait_bit(2);
      rd_word(a);
      chk_reg("program", {16'h0, d}, r);
      apb(1'b1, `REG_CFG, 32'h2);
      order(OP_CHIP_ERASE);
      wait_bit(2);
      rd_word(a);
      chk_reg("guarded", {16'h0, d}, r);
      apb(1'b1, `REG_CFG, 32'h3);
      order(OP_CHIP_ERASE);
      wait_bit(2);
      rd_word(a);
      chk_reg("erased", 32'hffff, r);
      $display("test erase done");
      apb(1'b1, `REG_ADDR, 32'h10800);
      order(OP_SECTOR_ERASE);
      wait_bit(1);
      order(OP_SUSPEND);
      wait_bit(2);
      chk_pin("suspended", 1'b1, r[3]);
      chk_pin("flag", 1'b0, r[4]);
      rd_word(20'h10801);
      chk_reg("suspended read", 32'hc0, r & 32'hc0);
      rd_word(20'h00100);
      chk_reg("other read", 32'hffff, r);
      apb(1'b1, `REG_ADDR, 32'h10800);
      order(OP_RESUME);
      wait_bit(2);
      chk_pin("resumed", 1'b0, r[3]);
      chk_pin("ready", 1'b0, r[4]);
      order(OP_BLOCK_ERASE);
      wait_bit(2);
      chk_pin("block ready", 1'b0, r[4]);
      $display("test suspend done");
      order(OP_RESET);
      wait_bit(2);
      chk_pin("reset done", 1'b1, r[2]);
      apb(1'b1, `REG_CFG, 32'h1);
      rd_word(a);
      chk_pin("width", 1'b0, fo.bus_width_select);
      chk_reg("byte read", 32'hff, r);
      $display("test reset and byte done");
      test_done();
   end
endmodule : test_flash_host_ctrl
`default_nettype wire

// file: verilog/flash_host_consts.svh
/*
   Constants of the flash host controller: register offsets, field
   positions, reset values, command codes and timing counts.
   Assumes a 200 MHz pclk and a flash part with the JEDEC command set.
*/
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define WE_PULSE_NS 40
`define WE_PULSE_CYC ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_NS 70
`define READ_ACCESS_CYC ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSPEND_LATENCY_NS 10000
`define SUSPEND_LATENCY_CYC ((`SUSPEND_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_ADDR 12'h004
`define REG_WDATA 12'h008
`define REG_CFG 12'h00c
`define REG_STATUS 12'h010
`define REG_RDATA 12'h014
`define CFG_WP_BIT 0
`define CFG_WIDE_BIT 1
`define CFG_RESET 2'h3
`define ADDR_LOW_BIT 20

// ----------------------------------------------------------------
// Command bus cycles
// ----------------------------------------------------------------
`define CMD_ADDR_A 20'h00555
`define CMD_ADDR_B 20'h002aa
`define CMD_UNLOCK_A 16'h00aa
`define CMD_UNLOCK_B 16'h0055
`define CMD_ERASE_SETUP 16'h0080
`define CMD_PROGRAM 16'h00a0
`define CMD_CHIP_ERASE 16'h0010
`define CMD_SECTOR_ERASE 16'h0030
`define CMD_BLOCK_ERASE 16'h0050
`define CMD_SUSPEND 16'h00b0
`define CMD_RESUME 16'h0030

`endif

// file: verilog/flash_host_ctrl.sv
/*
   Host-side controller for a dual-bank flash: turns APB orders into
   strobe sequences on the flash pins and polls status to completion.
   Assumes APB master on pclk and flash pins sampled on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_consts.svh"

module flash_host_ctrl #(
   parameter int RESET_PULSE_NS = 500,
   parameter int RESET_RECOVERY_NS = 50
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output flash_host_pkg::flash_out_t flash_out,
   input wire flash_host_pkg::flash_in_t flash_in
);
   import flash_host_pkg::*;

   // ----------------------------------------------------------------
   // Derived counts
   // ----------------------------------------------------------------
   // Minimum times, so round up
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int RESET_REC_CYC = (RESET_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int RST_LOW_N = (RESET_PULSE_CYC < 1) ? 1 : RESET_PULSE_CYC;
   localparam int RST_REC_N = (RESET_REC_CYC < 1) ? 1 : RESET_REC_CYC;

   ctl_t s; // Registered state
   ctl_t next_s; // Next state
   logic setup_ph; // APB setup cycle
   logic wr_acc; // APB write taking effect
   logic mapped; // Address hits a register
   logic tog_now; // Toggle bit of this poll read
   cmd_t cyc; // Command cycle for the next state

   // ----------------------------------------------------------------
   // Command table
   // ----------------------------------------------------------------
   // Address and data of one write cycle of an order
   function automatic cmd_t cmd_of(input op_t op, input logic [2:0] step,
                                   input logic [19:0] ua, input logic [15:0] ud);
      cmd_t c;
      c = '{addr: ua, data: `CMD_SUSPEND};
      if (op == OP_SUSPEND) begin
         c = '{addr: ua, data: `CMD_SUSPEND};
      end else if (op == OP_RESUME) begin
         c = '{addr: ua, data: `CMD_RESUME};
      end else begin
         unique case (step)
            3'h0, 3'h3: c = '{addr: `CMD_ADDR_A, data: `CMD_UNLOCK_A};
            3'h1, 3'h4: c = '{addr: `CMD_ADDR_B, data: `CMD_UNLOCK_B};
            3'h2: c = '{addr: `CMD_ADDR_A, data: (op == OP_PROGRAM) ? `CMD_PROGRAM : `CMD_ERASE_SETUP};
            default: c = '{addr: ua, data: (op == OP_BLOCK_ERASE) ? `CMD_BLOCK_ERASE : `CMD_SECTOR_ERASE};
         endcase
         if (op == OP_PROGRAM && step == 3'h3) begin
            c = '{addr: ua, data: ud};
         end
         if (op == OP_CHIP_ERASE && step == 3'h5) begin
            c = '{addr: `CMD_ADDR_A, data: `CMD_CHIP_ERASE};
         end
      end
      return c;
   endfunction : cmd_of

   // Last step index of an order's write sequence
   function automatic logic [2:0] last_step(input op_t op);
      logic [2:0] n;
      n = 3'h0;
      if (op == OP_PROGRAM) begin
         n = 3'h3;
      end else if (op == OP_CHIP_ERASE || op == OP_SECTOR_ERASE || op == OP_BLOCK_ERASE) begin
         n = 3'h5;
      end
      return n;
   endfunction : last_step

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_ADDR) || (paddr == `REG_WDATA) ||
                   (paddr == `REG_CFG) || (paddr == `REG_STATUS) || (paddr == `REG_RDATA);
   assign pready = 1'b1; // Every access ends in one access cycle
   assign prdata = s.prdata;
   assign pslverr = s.pslverr;
   assign flash_out = s.pins;
   assign tog_now = s.rdata[6];

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // One process for bus, sequencer and pins
   always_comb begin
      next_s = s;
      cyc = '0;
      // Read data and error are prepared in setup, shown in access
      if (setup_ph) begin
         next_s.pslverr = ~mapped;
         next_s.prdata = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               `REG_ADDR: next_s.prdata = {11'h000, s.addr};
               `REG_WDATA: next_s.prdata = {16'h0000, s.wdata};
               `REG_CFG: next_s.prdata = {30'h0000_0000, s.wide, s.wp};
               `REG_STATUS: next_s.prdata = {26'h000_0000, s.pend_susp, ~flash_in.op_progress_flag_n,
                                             s.suspended, s.done, s.polling, s.fsm != S_IDLE};
               `REG_RDATA: next_s.prdata = {16'h0000, s.rdata};
               default: next_s.prdata = 32'h0000_0000; // Unmapped or write-only
            endcase
         end
      end
      // Register writes
      if (wr_acc) begin
         if (paddr == `REG_ADDR && s.fsm == S_IDLE) begin
            next_s.addr = pwdata[20:0];
         end
         if (paddr == `REG_WDATA && s.fsm == S_IDLE) begin
            next_s.wdata = pwdata[15:0];
         end
         // Protect level and width stay frozen while busy
         if (paddr == `REG_CFG && s.fsm == S_IDLE) begin
            next_s.wp = pwdata[`CFG_WP_BIT];
            next_s.wide = pwdata[`CFG_WIDE_BIT];
         end
         if (paddr == `REG_CTRL) begin
            if (s.fsm == S_IDLE) begin
               // New order starts only from idle
               next_s.op = op_t'(pwdata[3:0]);
               next_s.step = 3'h0;
               next_s.done = 1'b0;
               next_s.rd = (op_t'(pwdata[3:0]) == OP_READ);
               next_s.polling = 1'b0;
               // A suspend that met the end of its erase must not hit the next order
               next_s.pend_susp = 1'b0;
               if (op_t'(pwdata[3:0]) == OP_RESET) begin
                  next_s.fsm = S_RST_LOW;
                  next_s.cnt = 16'(RST_LOW_N);
               end else if (pwdata[3:0] <= 4'h6) begin
                  next_s.fsm = S_SETUP;
               end
            end else if (op_t'(pwdata[3:0]) == OP_SUSPEND && s.polling &&
                         (s.op == OP_SECTOR_ERASE || s.op == OP_BLOCK_ERASE)) begin
               next_s.pend_susp = 1'b1;
            end
            // Anything else while busy is dropped, never sent
         end
      end
      // Sequencer
      unique case (s.fsm)
         S_IDLE: begin
            // Waiting for an order
         end
         S_SETUP: begin
            // Select and address settle before the strobe falls
            next_s.fsm = S_STROBE;
            next_s.cnt = s.rd ? 16'(`READ_ACCESS_CYC) : 16'(`WE_PULSE_CYC);
         end
         S_STROBE: begin
            next_s.cnt = s.cnt - 16'h0001;
            if (s.cnt == 16'h0001) begin
               next_s.fsm = S_HOLD;
               if (s.rd) begin
                  // Byte mode leaves the upper lines undriven
                  next_s.rdata = s.wide ? flash_in.dq_in : {8'h00, flash_in.dq_in[7:0]};
               end
            end
         end
         S_HOLD: begin
            // Select high for one cycle between bus cycles; strobes stay high through the next setup
            if (s.rd && s.polling) begin
               // Stable toggle bit on two rereads plus ready pin ends it
               next_s.tog_prev = tog_now;
               next_s.tog_valid = 1'b1;
               if (s.tog_valid && tog_now == s.tog_prev && flash_in.op_progress_flag_n) begin
                  next_s.confirm = s.confirm + 2'h1;
               end else begin
                  next_s.confirm = 2'h0;
               end
               if (s.tog_valid && tog_now == s.tog_prev && flash_in.op_progress_flag_n &&
                   s.confirm == 2'h1) begin
                  next_s.polling = 1'b0;
                  next_s.done = 1'b1;
                  next_s.fsm = S_IDLE;
               end else if (s.pend_susp) begin
                  next_s.pend_susp = 1'b0;
                  next_s.op = OP_SUSPEND;
                  next_s.rd = 1'b0;
                  next_s.polling = 1'b0;
                  next_s.step = 3'h0;
                  next_s.fsm = S_SETUP;
               end else begin
                  next_s.fsm = S_SETUP;
               end
            end else if (s.rd) begin
               next_s.done = 1'b1;
               next_s.fsm = S_IDLE;
            end else if (s.step != last_step(s.op)) begin
               next_s.step = s.step + 3'h1;
               next_s.fsm = S_SETUP;
            end else if (s.op == OP_SUSPEND) begin
               // Give the part its worst-case latency before reads
               next_s.suspended = 1'b1;
               next_s.cnt = 16'(`SUSPEND_LATENCY_CYC);
               next_s.fsm = S_WAIT;
            end else begin
               // Program, erase or resume: poll the bank at hand
               if (s.op == OP_RESUME) begin
                  next_s.op = OP_SECTOR_ERASE;
                  next_s.suspended = 1'b0;
               end
               next_s.rd = 1'b1;
               next_s.polling = 1'b1;
               next_s.tog_valid = 1'b0;
               next_s.confirm = 2'h0;
               next_s.fsm = S_SETUP;
            end
         end
         S_WAIT: begin
            next_s.cnt = s.cnt - 16'h0001;
            if (s.cnt == 16'h0001) begin
               next_s.done = 1'b1;
               next_s.fsm = S_IDLE;
            end
         end
         S_RST_LOW: begin
            // Abort wipes any erase in flight; software must redo it
            next_s.cnt = s.cnt - 16'h0001;
            next_s.suspended = 1'b0;
            next_s.pend_susp = 1'b0;
            next_s.polling = 1'b0;
            if (s.cnt == 16'h0001) begin
               next_s.cnt = 16'(RST_REC_N);
               next_s.fsm = S_RST_REC;
            end
         end
         S_RST_REC: begin
            next_s.cnt = s.cnt - 16'h0001;
            if (s.cnt == 16'h0001) begin
               next_s.done = 1'b1;
               next_s.fsm = S_IDLE;
            end
         end
         default: begin
            next_s.fsm = S_IDLE; // Illegal code recovers
         end
      endcase
      // Pins follow the next state so they leave flops
      cyc = cmd_of(next_s.op, next_s.step, next_s.addr[19:0], next_s.wdata);
      next_s.pins.flash_bank_select_n = ~(next_s.fsm == S_SETUP || next_s.fsm == S_STROBE);
      next_s.pins.we_n = ~(next_s.fsm == S_STROBE && !next_s.rd);
      next_s.pins.oe_n = ~(next_s.fsm == S_STROBE && next_s.rd);
      next_s.pins.reset_n = (next_s.fsm != S_RST_LOW);
      next_s.pins.wp_n = next_s.wp;
      next_s.pins.bus_width_select = next_s.wide;
      next_s.pins.addr = next_s.rd ? next_s.addr[19:0] : cyc.addr;
      next_s.pins.dq_out = next_s.wide ? cyc.data : {next_s.addr[`ADDR_LOW_BIT], 7'h00, cyc.data[7:0]};
      next_s.pins.dq_oe_n = 16'hffff;
      if (next_s.fsm == S_SETUP || next_s.fsm == S_STROBE) begin
         if (!next_s.wide) begin
            next_s.pins.dq_oe_n = {1'b0, 7'h7f, {8{next_s.rd}}};
         end else begin
            next_s.pins.dq_oe_n = {16{next_s.rd}};
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset leaves the flash deselected and unprotected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '{fsm: S_IDLE, op: OP_READ, wp: 1'(`CFG_RESET >> `CFG_WP_BIT), wide: 1'(`CFG_RESET >> `CFG_WIDE_BIT),
                pins: '{addr: 20'h00000, dq_out: 16'h0000, dq_oe_n: 16'hffff,
                        flash_bank_select_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, wp_n: 1'b1,
                        reset_n: 1'b1, bus_width_select: 1'b1},
                default: '0};
      end else begin
         s <= next_s;
      end
   end

endmodule : flash_host_ctrl
`default_nettype wire

// file: verilog/flash_host_pkg.sv
/*
   Types of the flash host controller: operations, sequencer states,
   pin groups and the controller's state record.
   Assumes the constants header is included by the design file.
*/
package flash_host_pkg;

   // Operations software can order
   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_PROGRAM = 4'h1, OP_CHIP_ERASE = 4'h2, OP_SECTOR_ERASE = 4'h3,
      OP_BLOCK_ERASE = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6, OP_RESET = 4'h7
   } op_t;

   // Bus cycle sequencer
   typedef enum logic [6:0] {
      S_IDLE = 7'h01, S_SETUP = 7'h02, S_STROBE = 7'h04, S_HOLD = 7'h08,
      S_WAIT = 7'h10, S_RST_LOW = 7'h20, S_RST_REC = 7'h40
   } seq_state_t;

   // Pins driven toward the flash
   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] dq_out;
      logic [15:0] dq_oe_n;
      logic flash_bank_select_n;
      logic we_n;
      logic oe_n;
      logic wp_n;
      logic reset_n;
      logic bus_width_select;
   } flash_out_t;

   // Pins read from the flash
   typedef struct packed {
      logic [15:0] dq_in;
      logic op_progress_flag_n;
   } flash_in_t;

   // One command bus cycle
   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] data;
   } cmd_t;

   // Whole controller state
   typedef struct packed {
      seq_state_t fsm;
      op_t op;
      logic [2:0] step;
      logic [15:0] cnt;
      logic [20:0] addr;
      logic [15:0] wdata;
      logic wp;
      logic wide;
      logic [15:0] rdata;
      logic [31:0] prdata;
      logic pslverr;
      logic done;
      logic suspended;
      logic pend_susp;
      logic rd;
      logic polling;
      logic tog_prev;
      logic tog_valid;
      logic [1:0] confirm;
      flash_out_t pins;
   } ctl_t;

endpackage : flash_host_pkg
